/* flash_prog_device.sv */
// Device end: single-wire UART programming port with code and data flash
// Behaviour
// - Code flash is 32 blocks of 1 KB
// - Data flash is 2 blocks of 512 bytes
// - Every program writes one aligned 32-bit word
// - Erase clears one whole block per region
// - CPU held while data flash is rewritten
// - One shared two-way line carries all traffic
// - Link runs fixed at 115200 bits per second
// - Flash changed only by commands from line
// - Programmer drives reset and partners the line
// - Line low at reset release selects programming
// - Unused pins keep reset state while programming
// - Programming logic runs from internal fast oscillator
`timescale 1ns/1ns
`default_nettype none
module flash_prog_device
   import flash_prog_pkg::*;
(
   input wire logic clk_in, // Internal high-speed oscillator clock
   input wire logic nrst_in, // Synchronous reset from programmer, active low
   prog_link_if.device link, // Shared programming line
   input wire logic cpu_rd_region_in, // Read region: 0 code, 1 data
   input wire logic [12:0] cpu_rd_addr_in, // Read word address
   output logic [31:0] cpu_rd_data_out, // Read word, one cycle later
   output logic prog_mode_out, // Programming mode active
   output logic pins_hold_out, // Other pins held in reset state
   output logic hoco_sel_out, // Fast internal oscillator selected
   output logic cpu_hold_out // Instruction execution must wait
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   typedef enum logic [6:0] {
      S_OP = 7'h01,
      S_BLK = 7'h02,
      S_IDX = 7'h04,
      S_DAT = 7'h08,
      S_EXEC = 7'h10,
      S_TURN = 7'h20,
      S_SEND = 7'h40
   } dev_state_t;

   logic [31:0] code_mem [0:CODE_WORDS-1];
   logic [31:0] data_mem [0:DATA_WORDS-1];
   dev_state_t state_q;
   logic mode_done_q, mode_q, armed_q;
   logic rx_busy_q, rx_stb_q;
   logic [6:0] rx_cnt_q;
   logic [3:0] rx_bit_q;
   logic [7:0] rx_sh_q, rx_byte_q;
   logic tx_busy_q, out_q, oe_q;
   logic [6:0] tx_cnt_q;
   logic [3:0] tx_bit_q;
   logic [9:0] tx_sh_q;
   logic [7:0] op_q, blk_q, idx_q, erase_cnt_q, reply_q;
   logic [31:0] word_q;
   logic [1:0] nbyte_q;
   logic [6:0] turn_cnt_q;
   logic hold_q;
   logic [31:0] rd_q;
   logic rx_en, tx_go, region, is_erase, cmd_ok, erase_last, wr_en, er_en;
   logic [12:0] wr_addr, er_addr;

   // Word address of a block and word index within the region
   function automatic logic [12:0] word_addr(input logic data_rgn, input logic [7:0] blk,
                                             input logic [7:0] idx);
      word_addr = data_rgn ? {5'h00, blk[0], idx[6:0]} : {blk[4:0], idx};
   endfunction

   // Block and index range check for the addressed region
   function automatic logic in_range(input logic data_rgn, input logic [7:0] blk,
                                     input logic [7:0] idx);
      if (data_rgn)
         in_range = (blk < 8'(DATA_BLOCKS)) && (idx < 8'(DATA_BLK_WORDS));
      else
         in_range = blk < 8'(CODE_BLOCKS);
   endfunction

   // ---------------------------------------------------------------
   // Mode selection at reset release
   // ---------------------------------------------------------------
   // Line level on the first edge after release picks the mode; the receiver is
   // armed only once the entry hold ends, so the long low level is not taken as frames
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         mode_done_q <= 1'b0;
         mode_q <= 1'b0;
         armed_q <= 1'b0;
      end else if (!mode_done_q) begin
         mode_done_q <= 1'b1;
         mode_q <= !link.line;
      end else if (mode_q && link.line) begin
         armed_q <= 1'b1;
      end
   end

   assign prog_mode_out = mode_q;
   assign pins_hold_out = mode_q;
   assign hoco_sel_out = mode_q;

   // ---------------------------------------------------------------
   // Receiver
   // ---------------------------------------------------------------
   assign rx_en = mode_q && armed_q && !tx_busy_q && (state_q inside {S_OP, S_BLK, S_IDX, S_DAT});

   // Mid-bit sampling of start, eight data bits and stop
   always_ff @(posedge clk_in) begin
      rx_stb_q <= 1'b0;
      if (!nrst_in) begin
         rx_busy_q <= 1'b0;
         rx_cnt_q <= 7'h00;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 8'h00;
         rx_byte_q <= 8'h00;
      end else if (!rx_busy_q) begin
         if (rx_en && !link.line) begin
            rx_busy_q <= 1'b1;
            rx_cnt_q <= HALF_M1;
            rx_bit_q <= 4'h0;
         end
      end else if (rx_cnt_q != 7'h00) begin
         rx_cnt_q <= rx_cnt_q - 7'h01;
      end else begin
         rx_cnt_q <= BIT_M1;
         rx_bit_q <= rx_bit_q + 4'h1;
         if (rx_bit_q == 4'h0) begin
            rx_busy_q <= !link.line; // False start drops back
         end else if (rx_bit_q == LAST_BIT) begin
            rx_busy_q <= 1'b0;
            rx_stb_q <= link.line;
            rx_byte_q <= rx_sh_q;
         end else begin
            rx_sh_q <= {link.line, rx_sh_q[7:1]};
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmitter
   // ---------------------------------------------------------------
   assign tx_go = (state_q == S_TURN) && (turn_cnt_q == 7'h00);

   // Drives the line only for the frame, then releases it
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         tx_busy_q <= 1'b0;
         tx_cnt_q <= 7'h00;
         tx_bit_q <= 4'h0;
         tx_sh_q <= 10'h3FF;
         out_q <= 1'b1;
         oe_q <= 1'b0;
      end else if (!tx_busy_q) begin
         if (tx_go) begin
            tx_busy_q <= 1'b1;
            tx_sh_q <= {1'b1, reply_q, 1'b0};
            tx_cnt_q <= BIT_M1;
            tx_bit_q <= 4'h0;
            out_q <= 1'b0;
            oe_q <= 1'b1;
         end
      end else if (tx_cnt_q != 7'h00) begin
         tx_cnt_q <= tx_cnt_q - 7'h01;
      end else if (tx_bit_q == LAST_BIT) begin
         tx_busy_q <= 1'b0;
         out_q <= 1'b1;
         oe_q <= 1'b0;
      end else begin
         tx_bit_q <= tx_bit_q + 4'h1;
         tx_sh_q <= {1'b1, tx_sh_q[9:1]};
         out_q <= tx_sh_q[1];
         tx_cnt_q <= BIT_M1;
      end
   end

   assign link.dev_out = out_q;
   assign link.dev_oe = oe_q;

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   assign region = op_q[0];
   assign is_erase = (op_q == OP_ER_CODE) || (op_q == OP_ER_DATA);
   assign cmd_ok = (is_erase || (op_q == OP_WR_CODE) || (op_q == OP_WR_DATA)) &&
                   in_range(region, blk_q, is_erase ? 8'h00 : idx_q);
   assign erase_last = erase_cnt_q == (region ? 8'(DATA_BLK_WORDS - 1) : 8'(CODE_BLK_WORDS - 1));
   assign wr_en = (state_q == S_EXEC) && cmd_ok && !is_erase;
   assign er_en = (state_q == S_EXEC) && cmd_ok && is_erase;
   assign wr_addr = word_addr(region, blk_q, idx_q);
   assign er_addr = word_addr(region, blk_q, erase_cnt_q);

   // Packet: op, block, then word index and four data bytes for a write
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         state_q <= S_OP;
         op_q <= 8'h00;
         blk_q <= 8'h00;
         idx_q <= 8'h00;
         word_q <= 32'h0000_0000;
         nbyte_q <= 2'h0;
         erase_cnt_q <= 8'h00;
         turn_cnt_q <= 7'h00;
         reply_q <= REPLY_NAK;
         hold_q <= 1'b0;
      end else begin
         unique case (state_q)
            S_OP: if (rx_stb_q) begin
               op_q <= rx_byte_q;
               state_q <= S_BLK;
            end
            S_BLK: if (rx_stb_q) begin
               blk_q <= rx_byte_q;
               erase_cnt_q <= 8'h00;
               if (is_erase) begin
                  state_q <= S_EXEC;
                  hold_q <= region;
               end else begin
                  state_q <= S_IDX;
               end
            end
            S_IDX: if (rx_stb_q) begin
               idx_q <= rx_byte_q;
               nbyte_q <= 2'h0;
               state_q <= S_DAT;
            end
            S_DAT: if (rx_stb_q) begin
               word_q <= {rx_byte_q, word_q[31:8]};
               nbyte_q <= nbyte_q + 2'h1;
               if (nbyte_q == 2'h3) begin
                  state_q <= S_EXEC;
                  hold_q <= region;
               end
            end
            S_EXEC: begin
               erase_cnt_q <= erase_cnt_q + 8'h01;
               if (!er_en || erase_last) begin
                  reply_q <= cmd_ok ? REPLY_ACK : REPLY_NAK;
                  turn_cnt_q <= BIT_M1;
                  hold_q <= 1'b0;
                  state_q <= S_TURN;
               end
            end
            S_TURN: if (turn_cnt_q != 7'h00) begin
               turn_cnt_q <= turn_cnt_q - 7'h01;
            end else begin
               state_q <= S_SEND;
            end
            S_SEND: if (!tx_busy_q) begin
               state_q <= S_OP;
            end
            default: state_q <= S_OP;
         endcase
      end
   end

   assign cpu_hold_out = hold_q;

   // ---------------------------------------------------------------
   // Flash arrays
   // ---------------------------------------------------------------
   // Code array: whole word written, block erased word by word
   always_ff @(posedge clk_in) begin
      if (wr_en && !region)
         code_mem[wr_addr] <= word_q;
      else if (er_en && !region)
         code_mem[er_addr] <= ERASED_WORD;
   end

   // Data array, same access pattern
   always_ff @(posedge clk_in) begin
      if (wr_en && region)
         data_mem[wr_addr[7:0]] <= word_q;
      else if (er_en && region)
         data_mem[er_addr[7:0]] <= ERASED_WORD;
   end

   // Registered read port for the user side
   always_ff @(posedge clk_in) begin
      if (!nrst_in)
         rd_q <= 32'h0000_0000;
      else
         rd_q <= cpu_rd_region_in ? data_mem[cpu_rd_addr_in[7:0]] : code_mem[cpu_rd_addr_in];
   end

   assign cpu_rd_data_out = rd_q;
endmodule
`default_nettype wire

/* flash_prog_pkg.sv */
// Shared constants for the single-wire flash programming link
package flash_prog_pkg;
   // ---------------------------------------------------------------
   // Clock and bit timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam int BAUD_BPS = 115_200;
   localparam int BIT_CYCLES = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
   localparam logic [6:0] BIT_M1 = 7'(BIT_CYCLES - 1);
   localparam logic [6:0] HALF_M1 = 7'(BIT_CYCLES / 2 - 1);
   localparam int FRAME_BITS = 10;
   localparam logic [3:0] LAST_BIT = 4'(FRAME_BITS - 1);

   // ---------------------------------------------------------------
   // Flash geometry
   // ---------------------------------------------------------------
   localparam int WORD_BYTES = 4;
   localparam int CODE_BLOCKS = 32;
   localparam int CODE_BLOCK_BYTES = 1024;
   localparam int DATA_BLOCKS = 2;
   localparam int DATA_BLOCK_BYTES = 512;
   localparam int CODE_BLK_WORDS = CODE_BLOCK_BYTES / WORD_BYTES;
   localparam int DATA_BLK_WORDS = DATA_BLOCK_BYTES / WORD_BYTES;
   localparam int CODE_WORDS = CODE_BLOCKS * CODE_BLK_WORDS;
   localparam int DATA_WORDS = DATA_BLOCKS * DATA_BLK_WORDS;
   localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

   // ---------------------------------------------------------------
   // Command and reply bytes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_WR_CODE = 8'h10;
   localparam logic [7:0] OP_WR_DATA = 8'h11;
   localparam logic [7:0] OP_ER_CODE = 8'h20;
   localparam logic [7:0] OP_ER_DATA = 8'h21;
   localparam logic [7:0] REPLY_ACK = 8'h06;
   localparam logic [7:0] REPLY_NAK = 8'h15;

   // ---------------------------------------------------------------
   // Mode entry timing driven by the programmer
   // ---------------------------------------------------------------
   localparam int RST_TIME_NS = 10_000;
   localparam int RST_CYCLES = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [10:0] RST_M1 = 11'(RST_CYCLES - 1);
   localparam int ENTRY_HOLD_NS = 100_000;
   localparam int ENTRY_CYCLES = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [10:0] ENTRY_M1 = 11'(ENTRY_CYCLES - 1);
endpackage

/* prog_link_if.sv */
// Single-wire programming link between programmer and device
`timescale 1ns/1ns
`default_nettype none
interface prog_link_if;
   logic host_out;
   logic host_oe;
   logic dev_out;
   logic dev_oe;
   logic dev_rst_n;
   wire logic line;

   // Open line is pulled high; an enabled driver sets its level, and a low drive wins if both ends drive
   assign line = (host_oe ? host_out : 1'b1) & (dev_oe ? dev_out : 1'b1);

   modport device (input line, output dev_out, output dev_oe);
   modport host (input line, output host_out, output host_oe, output dev_rst_n);
endinterface
`default_nettype wire

/* flash_prog_host.sv */
// Programmer end: drives device reset, mode entry and command frames
`timescale 1ns/1ns
`default_nettype none
module flash_prog_host
   import flash_prog_pkg::*;
(
   input wire logic clk_in, // System clock
   input wire logic nrst_in, // Synchronous reset, active low
   prog_link_if.host link, // Shared programming line
   input wire logic req_valid_in, // Command request
   input wire logic [7:0] req_op_in, // Operation byte
   input wire logic [7:0] req_block_in, // Block number
   input wire logic [7:0] req_index_in, // Word index in block
   input wire logic [31:0] req_data_in, // Word to program
   output logic req_ready_out, // Ready for a request
   output logic resp_valid_out, // Reply byte strobe
   output logic [7:0] resp_code_out // Reply byte
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   typedef enum logic [5:0] {
      H_RST = 6'h01,
      H_ENTRY = 6'h02,
      H_IDLE = 6'h04,
      H_SEND = 6'h08,
      H_WAIT = 6'h10,
      H_TURN = 6'h20
   } host_state_t;

   host_state_t state_q;
   logic [10:0] tmr_q;
   logic rst_n_q, ready_q, resp_q;
   logic [7:0] resp_byte_q;
   logic [55:0] pkt_q;
   logic [2:0] left_q;
   logic tx_busy_q, out_q, oe_q;
   logic [6:0] tx_cnt_q, rx_cnt_q;
   logic [3:0] tx_bit_q, rx_bit_q;
   logic [9:0] tx_sh_q;
   logic rx_busy_q, rx_stb_q;
   logic [7:0] rx_sh_q, rx_byte_q;
   logic tx_go, req_erase;

   assign req_erase = (req_op_in == OP_ER_CODE) || (req_op_in == OP_ER_DATA);
   assign tx_go = (state_q == H_SEND) && !tx_busy_q && (left_q != 3'h0);

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Reset pulse, entry hold, then one command and its reply at a time
   always_ff @(posedge clk_in) begin
      resp_q <= 1'b0;
      if (!nrst_in) begin
         state_q <= H_RST;
         tmr_q <= RST_M1;
         rst_n_q <= 1'b0;
         ready_q <= 1'b0;
         resp_byte_q <= 8'h00;
         pkt_q <= 56'h0;
         left_q <= 3'h0;
      end else begin
         unique case (state_q)
            H_RST: if (tmr_q != 11'h000) begin
               tmr_q <= tmr_q - 11'h001;
            end else begin
               rst_n_q <= 1'b1;
               tmr_q <= ENTRY_M1;
               state_q <= H_ENTRY;
            end
            H_ENTRY: if (tmr_q != 11'h000) begin
               tmr_q <= tmr_q - 11'h001;
            end else begin
               ready_q <= 1'b1;
               state_q <= H_IDLE;
            end
            H_IDLE: if (req_valid_in) begin
               pkt_q <= {req_data_in, req_index_in, req_block_in, req_op_in};
               left_q <= req_erase ? 3'h2 : 3'h7;
               ready_q <= 1'b0;
               state_q <= H_SEND;
            end
            H_SEND: if (tx_go) begin
               pkt_q <= {8'h00, pkt_q[55:8]};
               left_q <= left_q - 3'h1;
            end else if (!tx_busy_q && left_q == 3'h0) begin
               state_q <= H_WAIT;
            end
            H_WAIT: if (rx_stb_q) begin
               resp_byte_q <= rx_byte_q;
               resp_q <= 1'b1;
               tmr_q <= {4'h0, BIT_M1};
               state_q <= H_TURN;
            end
            // Stop sample is mid-bit: let the device finish and release the line
            H_TURN: if (tmr_q != 11'h000) begin
               tmr_q <= tmr_q - 11'h001;
            end else begin
               ready_q <= 1'b1;
               state_q <= H_IDLE;
            end
            default: state_q <= H_RST;
         endcase
      end
   end

   assign link.dev_rst_n = rst_n_q;
   assign req_ready_out = ready_q;
   assign resp_valid_out = resp_q;
   assign resp_code_out = resp_byte_q;

   // ---------------------------------------------------------------
   // Line driver
   // ---------------------------------------------------------------
   // Holds the line low through reset and entry, else sends frames
   always_ff @(posedge clk_in) begin
      if (!nrst_in || state_q == H_RST || state_q == H_ENTRY) begin
         tx_busy_q <= 1'b0;
         tx_cnt_q <= 7'h00;
         tx_bit_q <= 4'h0;
         tx_sh_q <= 10'h3FF;
         out_q <= 1'b0;
         oe_q <= 1'b1;
      end else if (!tx_busy_q) begin
         out_q <= 1'b1;
         oe_q <= 1'b0;
         if (tx_go) begin
            tx_busy_q <= 1'b1;
            tx_sh_q <= {1'b1, pkt_q[7:0], 1'b0};
            tx_cnt_q <= BIT_M1;
            tx_bit_q <= 4'h0;
            out_q <= 1'b0;
            oe_q <= 1'b1;
         end
      end else if (tx_cnt_q != 7'h00) begin
         tx_cnt_q <= tx_cnt_q - 7'h01;
      end else if (tx_bit_q == LAST_BIT) begin
         tx_busy_q <= 1'b0;
         out_q <= 1'b1;
         oe_q <= 1'b0;
      end else begin
         tx_bit_q <= tx_bit_q + 4'h1;
         tx_sh_q <= {1'b1, tx_sh_q[9:1]};
         out_q <= tx_sh_q[1];
         tx_cnt_q <= BIT_M1;
      end
   end

   assign link.host_out = out_q;
   assign link.host_oe = oe_q;

   // ---------------------------------------------------------------
   // Reply receiver
   // ---------------------------------------------------------------
   // Listens only while waiting for the reply
   always_ff @(posedge clk_in) begin
      rx_stb_q <= 1'b0;
      if (!nrst_in) begin
         rx_busy_q <= 1'b0;
         rx_cnt_q <= 7'h00;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 8'h00;
         rx_byte_q <= 8'h00;
      end else if (!rx_busy_q) begin
         if (state_q == H_WAIT && !link.line) begin
            rx_busy_q <= 1'b1;
            rx_cnt_q <= HALF_M1;
            rx_bit_q <= 4'h0;
         end
      end else if (rx_cnt_q != 7'h00) begin
         rx_cnt_q <= rx_cnt_q - 7'h01;
      end else begin
         rx_cnt_q <= BIT_M1;
         rx_bit_q <= rx_bit_q + 4'h1;
         if (rx_bit_q == 4'h0) begin
            rx_busy_q <= !link.line;
         end else if (rx_bit_q == LAST_BIT) begin
            rx_busy_q <= 1'b0;
            rx_stb_q <= link.line;
            rx_byte_q <= rx_sh_q;
         end else begin
            rx_sh_q <= {link.line, rx_sh_q[7:1]};
         end
      end
   end
endmodule
`default_nettype wire

/* flash_prog_link_asserts.sv */
// Concurrent checks on the shared single-wire programming link
`timescale 1ns/1ns
`default_nettype none
module flash_prog_link_asserts
   import flash_prog_pkg::*;
(
   input wire logic clk_in, // Link clock
   input wire logic nrst_in, // Synchronous reset, active low
   input wire logic host_out, // Host line level
   input wire logic host_oe, // Host drive enable
   input wire logic dev_out, // Device line level
   input wire logic dev_oe, // Device drive enable
   input wire logic dev_rst_n, // Device reset from host
   input wire logic line // Resolved shared line
);
   // ---------------------------------------------------------------
   // Helper counters
   // ---------------------------------------------------------------
   logic [10:0] run_q;
   logic [10:0] oe_cnt_q;
   logic prev_q;
   // Cycles the device has held its present level while driving
   always_ff @(posedge clk_in) begin
      if (!dev_oe) begin
         run_q <= 11'h000;
      end else if (dev_out != prev_q) begin
         run_q <= 11'h001;
      end else begin
         run_q <= run_q + 11'h001;
      end
   end
   // Last sampled device level
   always_ff @(posedge clk_in) begin
      prev_q <= dev_out;
   end
   // Cycles the device enable has been high
   always_ff @(posedge clk_in) begin
      oe_cnt_q <= dev_oe ? oe_cnt_q + 11'h001 : 11'h000;
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_one_driver: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !(host_oe && dev_oe)) else $error("both ends drive the line");
   a_reset_line_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !dev_rst_n |-> host_oe && !host_out) else $error("line not low during device reset");
   a_entry_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $rose(dev_rst_n) |-> (host_oe && !host_out) [*8]) else $error("line not held low at release");
   a_dev_quiet_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !dev_rst_n |=> !dev_oe) else $error("device drives while in reset");
   a_dev_start_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $rose(dev_oe) |-> !dev_out && !line) else $error("device frame without low start");
   a_dev_stop_high: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $fell(dev_oe) |-> $past(dev_out)) else $error("device released before high stop");
   a_dev_bit_time: assert property (@(posedge clk_in) disable iff (!nrst_in)
      dev_oe && dev_out != prev_q && run_q != 11'h000 |-> run_q % BIT_CYCLES == 0)
      else $error("device bit length wrong");
   a_dev_frame_len: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $fell(dev_oe) |-> oe_cnt_q == FRAME_BITS * BIT_CYCLES) else $error("device frame length wrong");
   a_dev_turnaround: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $rose(dev_oe) |-> !$past(host_oe, 32)) else $error("device answers without turnaround");
endmodule
`default_nettype wire

/* test_flash_serial_programming_port.sv */
// Self-checking bench joining the programmer and device ends
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin mismatches++; $display("mismatch at %0t: %s", $time, m); end end
module test_flash_serial_programming_port;
   import flash_prog_pkg::*;
   logic clk_in = 1'b0;
   logic sys_rst_n = 1'b0;
   logic req_valid, req_ready, resp_valid, rd_region, rd_tick, rd_tick_q, prog_mode, pins_hold, hoco_sel, cpu_hold;
   logic [7:0] req_op, req_block, req_index, resp_code, idx0;
   logic [12:0] rd_addr;
   logic [31:0] req_data, rd_data, w0, w1, w2;
   logic [7:0] exp_q[$];
   logic [31:0] rd_q[$];
   int mismatches = 0;
   int cmp_count = 0;
   int hold_cnt = 0;
   prog_link_if u_prog_link_if();
   wire logic dev_nrst = u_prog_link_if.dev_rst_n & sys_rst_n;
   flash_prog_host u_flash_prog_host(.clk_in(clk_in), .nrst_in(sys_rst_n), .link(u_prog_link_if),
      .req_valid_in(req_valid), .req_op_in(req_op), .req_block_in(req_block), .req_index_in(req_index),
      .req_data_in(req_data), .req_ready_out(req_ready), .resp_valid_out(resp_valid), .resp_code_out(resp_code));
   flash_prog_device u_flash_prog_device(.clk_in(clk_in), .nrst_in(dev_nrst), .link(u_prog_link_if),
      .cpu_rd_region_in(rd_region), .cpu_rd_addr_in(rd_addr), .cpu_rd_data_out(rd_data),
      .prog_mode_out(prog_mode), .pins_hold_out(pins_hold), .hoco_sel_out(hoco_sel), .cpu_hold_out(cpu_hold));
   flash_prog_link_asserts u_flash_prog_link_asserts(.clk_in(clk_in), .nrst_in(sys_rst_n),
      .host_out(u_prog_link_if.host_out), .host_oe(u_prog_link_if.host_oe), .dev_out(u_prog_link_if.dev_out),
      .dev_oe(u_prog_link_if.dev_oe), .dev_rst_n(u_prog_link_if.dev_rst_n), .line(u_prog_link_if.line));
   // Clock at 10 MHz
   always #50 clk_in = ~clk_in;
   // Verdict and end of run
   task automatic stop_test();
      if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Bounded wait for the host to accept a request
   task automatic wait_ready();
      int n;
      for (n = 0; n < 20000 && req_ready !== 1'b1; n++) begin
         @(posedge clk_in);
         #1;
      end
      if (req_ready !== 1'b1) begin
         mismatches++;
         $display("mismatch at %0t: host never ready", $time);
         stop_test();
      end
   endtask
   // One command packet with its expected reply
   task automatic send(input logic [7:0] op, input logic [7:0] b, input logic [7:0] i, input logic [31:0] d,
                       input logic [7:0] e);
      wait_ready();
      req_op = op;
      req_block = b;
      req_index = i;
      req_data = d;
      req_valid = 1'b1;
      exp_q.push_back(e);
      @(posedge clk_in);
      #1 req_valid = 1'b0;
   endtask
   // Word read on the device read port with its expected value
   task automatic rd(input logic sel, input logic [12:0] a, input logic [31:0] e);
      rd_region = sel;
      rd_addr = a;
      rd_tick = 1'b1;
      rd_q.push_back(e);
      @(posedge clk_in);
      #1 rd_tick = 1'b0;
      @(posedge clk_in);
      #1;
   endtask
   // Output watcher: replies, read words and hold cycles
   always @(posedge clk_in) begin
      rd_tick_q <= rd_tick;
      if (cpu_hold === 1'b1) hold_cnt++;
      if (resp_valid === 1'b1) begin
         `CHK(resp_code, exp_q.pop_front(), "reply code")
      end
      if (rd_tick_q === 1'b1) begin
         `CHK(rd_data, rd_q.pop_front(), "read word")
      end
   end
   // Main sequence
   initial begin
      int n;
      req_valid = 1'b0;
      req_op = 8'h00;
      req_block = 8'h00;
      req_index = 8'h00;
      req_data = 32'h0000_0000;
      rd_region = 1'b0;
      rd_addr = 13'h0000;
      rd_tick = 1'b0;
      w0 = $urandom(12);
      w1 = $urandom;
      w2 = $urandom;
      idx0 = 8'($urandom_range(255));
      repeat (2) @(posedge clk_in);
      #1 sys_rst_n = 1'b1;
      wait_ready();
      `CHK({prog_mode, pins_hold, hoco_sel}, 3'b111, "mode flags")
      send(OP_WR_CODE, 8'h1F, 8'hFF, w0, REPLY_ACK);
      send(OP_WR_CODE, 8'h00, idx0, w1, REPLY_ACK);
      wait_ready();
      rd(1'b0, 13'h1FFF, w0);
      rd(1'b0, {5'h00, idx0}, w1);
      `CHK(hold_cnt, 0, "hold on code write")
      send(OP_WR_DATA, 8'h01, 8'h7F, w2, REPLY_ACK);
      wait_ready();
      `CHK(hold_cnt > 0, 1'b1, "no hold on data write")
      send(OP_WR_DATA, 8'h01, 8'h80, w0, REPLY_NAK);
      send(OP_ER_DATA, 8'h02, 8'h00, 32'h0000_0000, REPLY_NAK);
      wait_ready();
      rd(1'b1, 13'h00FF, w2);
      send(OP_ER_CODE, 8'h1F, 8'h00, 32'h0000_0000, REPLY_ACK);
      send(OP_ER_DATA, 8'h01, 8'h00, 32'h0000_0000, REPLY_ACK);
      wait_ready();
      rd(1'b0, 13'h1FFF, ERASED_WORD);
      rd(1'b0, 13'h1F00, ERASED_WORD);
      rd(1'b0, {5'h00, idx0}, w1);
      rd(1'b1, 13'h00FF, ERASED_WORD);
      rd(1'b1, 13'h0080, ERASED_WORD);
      for (n = 0; n < 100 && (exp_q.size() != 0 || rd_q.size() != 0); n++) @(posedge clk_in);
      if (exp_q.size() != 0 || rd_q.size() != 0) begin
         mismatches++;
         $display("mismatch at %0t: results missing", $time);
      end
      stop_test();
   end
endmodule
`default_nettype wire
